// ==== hbi_defines.svh ====
`ifndef HBI_DEFINES_SVH
`define HBI_DEFINES_SVH

`define HBI_ADDR_W 32
`define HBI_DATA_W 64
`define HBI_LANE_W 16
`define HBI_LANES 4
`define HBI_LANE_LOW_MAX 8
`define HBI_LINE_BYTES 64
`define HBI_BEATS_PER_LINE 8
`define HBI_IOQ_DEPTH 12
`define HBI_IOQ_CNT_W 4
`define HBI_DEFER_MAX 1
`define HBI_ADDR_GAP 2
`define HBI_MSI_TOP 12'hFEE
`define HBI_IO_CFG_BASE 16'h0CF8
`define HBI_IO_CFG_LAST 16'h0CFF

`endif

// ==== hbi_pkg.sv ====
package hbi_pkg;
   typedef enum logic [1:0] {
      HBI_IO_TO_GFX,
      HBI_IO_TO_HUB,
      HBI_IO_TO_CFG
   } hbi_io_dest_type;
   typedef enum logic [1:0] {
      HBI_MEM_TO_GFX,
      HBI_MEM_TO_HUB,
      HBI_MEM_TO_DRAM
   } hbi_mem_dest_type;
   typedef enum logic [1:0] {
      HBI_IN_NONE,
      HBI_IN_HUB,
      HBI_IN_GFX_PCI,
      HBI_IN_GFX_NATIVE
   } hbi_in_src_type;
endpackage

// ==== hbi_lane_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface hbi_lane_if;
   logic [63:0] rawData;
   logic [63:0] busData;
   logic [3:0] busFlags;
   logic [63:0] rxBus;
   logic [3:0] rxFlags;
   logic [63:0] rxData;
   modport user (output rawData, output rxBus, output rxFlags,
      input busData, input busFlags, input rxData);
   modport coder (input rawData, input rxBus, input rxFlags,
      output busData, output busFlags, output rxData);
endinterface
`default_nettype wire

// ==== hbi_lane_coder.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hbi_defines.svh"
module hbi_lane_coder (
   hbi_lane_if.coder lanes
);
   import hbi_pkg::*;
   genvar g;
   generate
      for (g = 0; g < `HBI_LANES; g++) begin : gLane
         logic [4:0] zeros;
         logic inv;
         always_comb begin
            zeros = 5'h00;
            for (int b = 0; b < `HBI_LANE_W; b++) begin
               // concatenation keeps the inversion one bit wide
               zeros = zeros + {4'h0, ~lanes.rawData[g*16+b]};
            end
         end
         // low count over eight flips the lane
         assign inv = (zeros > 5'(`HBI_LANE_LOW_MAX)); // RULE13
         // flag g covers bits 16g+15:16g
         assign lanes.busFlags[g] = inv; // RULE12
         assign lanes.busData[g*16 +: 16] =
            inv ? ~lanes.rawData[g*16 +: 16] : lanes.rawData[g*16 +: 16];
         assign lanes.rxData[g*16 +: 16] = lanes.rxFlags[g] ? // RULE14
            ~lanes.rxBus[g*16 +: 16] : lanes.rxBus[g*16 +: 16];
      end
   endgenerate
endmodule
`default_nettype wire

// ==== hbi_host_bus_interface.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hbi_defines.svh"
// Notes on behaviour
// RULE1: host addresses are 32 bits, covering a 4 GB memory space.
// RULE2: each host I/O cycle goes to graphics, hub link or config.
// RULE3: each host memory cycle goes to graphics, hub link or memory.
// RULE4: host accesses hitting the graphics aperture are translated first.
// RULE5: graphics-port accesses to non-cacheable memory are not snooped.
// RULE6: hub-link and PCI-style graphics memory accesses are snooped.
// RULE7: a coherent line is 64 bytes on the host bus.
// RULE8: address twice per clock; new request at most every other clock.
// RULE9: data four times per clock; a line takes two clocks.
// RULE10: at most 12 transactions held in the in-order queue.
// RULE11: at most one deferred transaction outstanding.
// RULE12: inversion flag n covers data lane bits 16n+15 to 16n.
// RULE13: a lane with more than 8 low bits is sent inverted, flagged.
// RULE14: received lanes with flag set are inverted back.
// RULE15: downstream interrupts are driven onto the host bus by us.
// RULE16: inbound writes to the interrupt window become interrupt messages; the code converts hub-link and PCI-style graphics writes only.
// RULE17: interrupt writes post like other writes, else retry.
// RULE18: writes outside the window stay normal memory writes.
module hbi_host_bus_interface (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic busClock,
   input wire logic reqValid,
   input wire logic reqIsIo,
   input wire logic reqDeferrable,
   input wire logic [31:0] reqAddr,
   input wire logic reqDone,
   input wire logic deferDone,
   input wire logic [31:0] gfxMemBase,
   input wire logic [31:0] gfxMemLimit,
   input wire logic [31:0] apertureBase,
   input wire logic [31:0] apertureLimit,
   input wire logic [31:0] topOfMemory,
   input wire logic [31:0] gfxIoBase,
   input wire logic [31:0] gfxIoLimit,
   input wire logic inValid,
   input wire hbi_pkg::hbi_in_src_type inSrc,
   input wire logic inNonCacheable,
   input wire logic [31:0] inAddr,
   input wire logic inBufSpace,
   input wire logic [63:0] txData,
   input wire logic [63:0] host_data_lines,
   input wire logic [3:0] lane_inversion_flags,
   output logic reqTaken,
   output logic reqRetry,
   output hbi_pkg::hbi_io_dest_type ioDest,
   output hbi_pkg::hbi_mem_dest_type memDest,
   output logic routeValid,
   output logic needTranslate,
   output logic deferIssued,
   output logic [3:0] queueCount,
   output logic inPosted,
   output logic inRetry,
   output logic snoopReq,
   output logic intMsgReq,
   output logic [31:0] intMsgAddr,
   output logic [63:0] busDataOut,
   output logic [3:0] busFlagsOut,
   output logic [63:0] rxDataOut
);
   import hbi_pkg::*;
   logic rstMeta, rstSync;
   logic lrMeta, lrSync;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end
   always_ff @(posedge busClock or negedge arst_n) begin
      if (!arst_n) begin
         lrMeta <= 1'b0;
         lrSync <= 1'b0;
      end else begin
         lrMeta <= 1'b1;
         lrSync <= lrMeta;
      end
   end

   // link-side request pacing, one request per two bus clocks
   logic gapOk, next_gapOk;
   logic linkTog, next_linkTog;
   logic [31:0] linkAddr, next_linkAddr;
   logic linkIo, next_linkIo, linkDef, next_linkDef;
   always_comb begin
      next_gapOk = 1'b1;
      next_linkTog = linkTog;
      next_linkAddr = linkAddr;
      next_linkIo = linkIo;
      next_linkDef = linkDef;
      if (reqValid && gapOk) begin // RULE8
         next_gapOk = 1'b0;
         next_linkTog = ~linkTog;
         next_linkAddr = reqAddr; // RULE1
         next_linkIo = reqIsIo;
         next_linkDef = reqDeferrable;
      end
   end
   always_ff @(posedge busClock or negedge lrSync) begin
      if (!lrSync) begin
         gapOk <= 1'b1;
         linkTog <= 1'b0;
         linkAddr <= 32'h0000_0000;
         linkIo <= 1'b0;
         linkDef <= 1'b0;
      end else begin
         gapOk <= next_gapOk;
         linkTog <= next_linkTog;
         linkAddr <= next_linkAddr;
         linkIo <= next_linkIo;
         linkDef <= next_linkDef;
      end
   end

   // toggle crossing; payload is stable two link clocks past the toggle
   logic togM, togS, togD;
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         togM <= 1'b0;
         togS <= 1'b0;
         togD <= 1'b0;
      end else begin
         togM <= linkTog;
         togS <= togM;
         togD <= togS;
      end
   end
   logic newReq;
   assign newReq = togS ^ togD;

   // in-order queue and deferral bookkeeping
   logic [3:0] qCnt, next_qCnt;
   logic defBusy, next_defBusy;
   logic next_reqTaken, next_reqRetry, next_routeValid, next_needTranslate;
   logic next_deferIssued;
   hbi_io_dest_type next_ioDest;
   hbi_mem_dest_type next_memDest;
   logic qFull, hitGfx, hitAper, hitIoGfx, hitCfg;
   always_comb begin
      qFull = (qCnt == 4'(`HBI_IOQ_DEPTH));
      hitAper = (linkAddr >= apertureBase) && (linkAddr <= apertureLimit);
      hitGfx = (linkAddr >= gfxMemBase) && (linkAddr <= gfxMemLimit);
      hitIoGfx = (linkAddr >= gfxIoBase) && (linkAddr <= gfxIoLimit);
      hitCfg = (linkAddr[15:0] >= `HBI_IO_CFG_BASE) &&
         (linkAddr[15:0] <= `HBI_IO_CFG_LAST);
      next_qCnt = qCnt;
      next_defBusy = defBusy;
      next_reqTaken = 1'b0;
      next_reqRetry = 1'b0;
      next_routeValid = 1'b0;
      next_needTranslate = 1'b0;
      next_deferIssued = 1'b0;
      next_ioDest = ioDest;
      next_memDest = memDest;
      if (reqDone && qCnt != 4'h0) begin
         next_qCnt = qCnt - 4'h1;
      end
      if (deferDone) begin
         next_defBusy = 1'b0;
      end
      if (newReq) begin
         if (qFull || (linkDef && defBusy)) begin // RULE10 RULE11
            next_reqRetry = 1'b1;
         end else begin
            next_reqTaken = 1'b1;
            next_routeValid = 1'b1;
            next_qCnt = next_qCnt + 4'h1; // RULE10
            if (linkDef) begin
               next_defBusy = 1'b1; // RULE11
               next_deferIssued = 1'b1;
            end
            if (linkIo) begin // RULE2
               if (hitCfg) next_ioDest = HBI_IO_TO_CFG;
               else if (hitIoGfx) next_ioDest = HBI_IO_TO_GFX;
               else next_ioDest = HBI_IO_TO_HUB;
            end else begin // RULE3
               next_needTranslate = hitAper; // RULE4
               if (hitAper || hitGfx) next_memDest = HBI_MEM_TO_GFX;
               else if (linkAddr < topOfMemory)
                  next_memDest = HBI_MEM_TO_DRAM;
               else next_memDest = HBI_MEM_TO_HUB;
            end
         end
      end
   end

   // inbound snoop and interrupt message conversion
   logic next_inPosted, next_inRetry, next_snoopReq, next_intMsgReq;
   logic [31:0] next_intMsgAddr;
   logic inPci, inWin;
   always_comb begin
      inPci = (inSrc == HBI_IN_HUB) || (inSrc == HBI_IN_GFX_PCI);
      inWin = (inAddr[31:20] == `HBI_MSI_TOP);
      next_inPosted = 1'b0;
      next_inRetry = 1'b0;
      next_snoopReq = 1'b0;
      next_intMsgReq = 1'b0;
      next_intMsgAddr = intMsgAddr;
      if (inValid && inSrc != HBI_IN_NONE) begin
         if (!inBufSpace) begin
            next_inRetry = 1'b1; // RULE17
         end else begin
            next_inPosted = 1'b1; // RULE17
            if (inPci && inWin) begin // RULE16 RULE15
               next_intMsgReq = 1'b1;
               next_intMsgAddr = inAddr;
            end else if (inAddr < topOfMemory) begin // RULE18
               // whole 64-byte line is snooped
               next_snoopReq = inPci || !inNonCacheable; // RULE5 RULE6 RULE7
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         qCnt <= 4'h0;
         defBusy <= 1'b0;
         reqTaken <= 1'b0;
         reqRetry <= 1'b0;
         routeValid <= 1'b0;
         needTranslate <= 1'b0;
         deferIssued <= 1'b0;
         ioDest <= HBI_IO_TO_HUB;
         memDest <= HBI_MEM_TO_HUB;
         queueCount <= 4'h0;
         inPosted <= 1'b0;
         inRetry <= 1'b0;
         snoopReq <= 1'b0;
         intMsgReq <= 1'b0;
         intMsgAddr <= 32'h0000_0000;
      end else begin
         qCnt <= next_qCnt;
         defBusy <= next_defBusy;
         reqTaken <= next_reqTaken;
         reqRetry <= next_reqRetry;
         routeValid <= next_routeValid;
         needTranslate <= next_needTranslate;
         deferIssued <= next_deferIssued;
         ioDest <= next_ioDest;
         memDest <= next_memDest;
         queueCount <= next_qCnt;
         inPosted <= next_inPosted;
         inRetry <= next_inRetry;
         snoopReq <= next_snoopReq;
         intMsgReq <= next_intMsgReq;
         intMsgAddr <= next_intMsgAddr;
      end
   end

   // data lanes: one 64-bit beat per clock here; pumping is in the pads
   hbi_lane_if lanes ();
   hbi_lane_coder uCoder (.lanes(lanes));
   logic [63:0] rxM, rxS;
   logic [3:0] rxfM, rxfS;
   assign lanes.rawData = txData;
   assign lanes.rxBus = rxS;
   assign lanes.rxFlags = rxfS;
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         rxM <= 64'h0;
         rxS <= 64'h0;
         rxfM <= 4'h0;
         rxfS <= 4'h0;
         busDataOut <= 64'h0;
         busFlagsOut <= 4'h0;
         rxDataOut <= 64'h0;
      end else begin
         rxM <= host_data_lines;
         rxS <= rxM;
         rxfM <= lane_inversion_flags;
         rxfS <= rxfM;
         busDataOut <= lanes.busData; // RULE13 RULE9
         busFlagsOut <= lanes.busFlags; // RULE12
         rxDataOut <= lanes.rxData; // RULE14
      end
   end

   a_queue_bound: assert property (@(posedge clock) disable iff (!rstSync)
      qCnt <= 4'(`HBI_IOQ_DEPTH)) else $error("queue over depth"); // RULE10
   a_full_retry: assert property (@(posedge clock) disable iff (!rstSync)
      newReq && qFull |=> reqRetry && !reqTaken)
      else $error("full queue took request"); // RULE10
   a_one_defer: assert property (@(posedge clock) disable iff (!rstSync)
      newReq && linkDef && defBusy && !deferDone |=> !deferIssued)
      else $error("second deferral"); // RULE11
   a_msi_convert: assert property (@(posedge clock) disable iff (!rstSync)
      inValid && inBufSpace && inPci && inWin |=> intMsgReq && !snoopReq)
      else $error("interrupt write not converted"); // RULE16
   a_no_space: assert property (@(posedge clock) disable iff (!rstSync)
      inValid && inSrc != HBI_IN_NONE && !inBufSpace |=> inRetry && !inPosted)
      else $error("write posted without space"); // RULE17
   a_normal_write: assert property (@(posedge clock) disable iff (!rstSync)
      inValid && !inWin |=> !intMsgReq)
      else $error("normal write became message"); // RULE18
   a_nc_nosnoop: assert property (@(posedge clock) disable iff (!rstSync)
      inValid && inSrc == HBI_IN_GFX_NATIVE && inNonCacheable |=> !snoopReq)
      else $error("non-cacheable snooped"); // RULE5
   a_aper_xlate: assert property (@(posedge clock) disable iff (!rstSync)
      newReq && !qFull && !linkIo && hitAper && !(linkDef && defBusy)
      |=> needTranslate && memDest == HBI_MEM_TO_GFX)
      else $error("aperture not translated"); // RULE4
   a_addr_gap: assert property (@(posedge busClock) disable iff (!lrSync)
      $changed(linkTog) |=> !$changed(linkTog))
      else $error("requests too close"); // RULE8
endmodule
`default_nettype wire

// ==== hbi_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module hbi_host_model (
   input wire logic busClock,
   output logic reqValid,
   output logic reqIsIo,
   output logic reqDeferrable,
   output logic [31:0] reqAddr,
   output logic [63:0] hostData,
   output logic [3:0] hostFlags
);
   initial begin
      reqValid = 1'b0;
      reqIsIo = 1'b0;
      reqDeferrable = 1'b0;
      reqAddr = 32'h0;
      hostData = 64'hFFFF_FFFF_FFFF_FFFF;
      hostFlags = 4'h0;
   end
   // flags in bits 67:64, high means the lane went out inverted
   function automatic logic [67:0] encode(input logic [63:0] raw);
      logic [67:0] r;
      int zeros;
      r = {4'h0, raw};
      for (int l = 0; l < 4; l++) begin
         zeros = 0;
         for (int b = 0; b < 16; b++) begin
            zeros += int'(raw[16*l+b] == 1'b0);
         end
         if (zeros > 8) begin
            r[16*l +: 16] = ~raw[16*l +: 16];
            r[64+l] = 1'b1;
         end
      end
      return r;
   endfunction
   task automatic sendData(input logic [63:0] raw);
      {hostFlags, hostData} = encode(raw);
   endtask
   // held for one link edge only; the spare edge keeps the address gap
   task automatic request(input logic io, input logic dfr,
         input logic [31:0] a);
      @(posedge busClock);
      #1;
      reqValid = 1'b1;
      reqIsIo = io;
      reqDeferrable = dfr;
      reqAddr = a;
      @(posedge busClock);
      #1;
      reqValid = 1'b0;
      reqAddr = ~a;
      @(posedge busClock);
   endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("[FAIL] %0t got %h want %h", $time, got, exp); \
      end \
   end
module testbench;
   import hbi_pkg::*;
   logic clock = 0, busClock = 0, arst_n = 1, reqDone = 0, deferDone = 0;
   logic inValid = 0, inNonCacheable = 0, inBufSpace = 0;
   hbi_in_src_type inSrc = HBI_IN_NONE;
   logic [31:0] inAddr = 0, gfxMemBase = 32'hD000_0000;
   logic [31:0] gfxMemLimit = 32'hD0FF_FFFF, apertureBase = 32'hE000_0000;
   logic [31:0] apertureLimit = 32'hE0FF_FFFF, topOfMemory = 32'h4000_0000;
   logic [31:0] gfxIoBase = 32'h0000_D000, gfxIoLimit = 32'h0000_DFFF;
   logic [63:0] txData = 0;
   logic reqValid, reqIsIo, reqDeferrable, reqTaken, reqRetry, routeValid;
   logic needTranslate, deferIssued, inPosted, inRetry, snoopReq, intMsgReq;
   logic [31:0] reqAddr, intMsgAddr;
   logic [63:0] hostData, busDataOut, rxDataOut;
   logic [3:0] hostFlags, queueCount, busFlagsOut;
   hbi_io_dest_type ioDest;
   hbi_mem_dest_type memDest;
   int fails = 0, compares = 0, qCnt = 0, defOpen = 0;
   initial forever #5 clock = ~clock;
   initial begin
      #7;
      forever #15 busClock = ~busClock;
   end
   hbi_host_model u_hbi_host_model (.busClock(busClock), .reqValid(reqValid),
      .reqIsIo(reqIsIo), .reqDeferrable(reqDeferrable), .reqAddr(reqAddr),
      .hostData(hostData), .hostFlags(hostFlags));
   hbi_host_bus_interface u_hbi_host_bus_interface (.clock(clock),
      .arst_n(arst_n), .busClock(busClock), .reqValid(reqValid),
      .reqIsIo(reqIsIo), .reqDeferrable(reqDeferrable), .reqAddr(reqAddr),
      .reqDone(reqDone), .deferDone(deferDone), .gfxMemBase(gfxMemBase),
      .gfxMemLimit(gfxMemLimit), .apertureBase(apertureBase),
      .apertureLimit(apertureLimit), .topOfMemory(topOfMemory),
      .gfxIoBase(gfxIoBase), .gfxIoLimit(gfxIoLimit), .inValid(inValid),
      .inSrc(inSrc), .inNonCacheable(inNonCacheable), .inAddr(inAddr),
      .inBufSpace(inBufSpace), .txData(txData), .host_data_lines(hostData),
      .lane_inversion_flags(hostFlags), .reqTaken(reqTaken),
      .reqRetry(reqRetry), .ioDest(ioDest), .memDest(memDest),
      .routeValid(routeValid), .needTranslate(needTranslate),
      .deferIssued(deferIssued), .queueCount(queueCount),
      .inPosted(inPosted), .inRetry(inRetry), .snoopReq(snoopReq),
      .intMsgReq(intMsgReq), .intMsgAddr(intMsgAddr),
      .busDataOut(busDataOut), .busFlagsOut(busFlagsOut),
      .rxDataOut(rxDataOut));
   task automatic results;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic tx(input logic [63:0] raw);
      logic [67:0] e;
      e = u_hbi_host_model.encode(raw);
      @(posedge clock);
      #1;
      txData = raw;
      repeat (2) @(posedge clock);
      #1;
      `CHK(busDataOut, e[63:0])
      `CHK(busFlagsOut, e[67:64])
   endtask
   task automatic rx(input logic [63:0] raw);
      @(posedge clock);
      #1;
      u_hbi_host_model.sendData(raw);
      repeat (5) @(posedge clock);
      #1;
      `CHK(rxDataOut, raw)
   endtask
   task automatic inbound(input hbi_in_src_type s, input logic [31:0] a,
         input logic sp);
      logic win, up, nc;
      win = a[31:20] == 12'hFEE;
      up = s == HBI_IN_HUB || s == HBI_IN_GFX_PCI;
      nc = s == HBI_IN_GFX_NATIVE && $urandom_range(1, 0) == 1;
      @(posedge clock);
      #1;
      inValid = 1'b1;
      inSrc = s;
      inAddr = a;
      inBufSpace = sp;
      inNonCacheable = nc;
      @(posedge clock);
      #1;
      inValid = 1'b0;
      `CHK(inPosted, sp)
      `CHK(inRetry, !sp)
      `CHK(intMsgReq, sp && win && up)
      if (sp && win && up) `CHK(intMsgAddr, a)
      if (sp && !win) `CHK(snoopReq, (up || !nc) && a < topOfMemory)
   endtask
   // one request through the model; the answer pulse is caught alongside
   task automatic hostReq(input logic io, input logic dfr,
         input logic [31:0] a);
      logic take, ap;
      hbi_io_dest_type ioE;
      hbi_mem_dest_type memE;
      ap = !io && a >= apertureBase && a <= apertureLimit;
      take = qCnt < 12 && !(dfr && defOpen != 0);
      ioE = (a >= gfxIoBase && a <= gfxIoLimit) ? HBI_IO_TO_GFX :
         (a >= 32'h0CF8 && a <= 32'h0CFF) ? HBI_IO_TO_CFG : HBI_IO_TO_HUB;
      memE = (ap || (a >= gfxMemBase && a <= gfxMemLimit)) ? HBI_MEM_TO_GFX :
         a < topOfMemory ? HBI_MEM_TO_DRAM : HBI_MEM_TO_HUB;
      fork
         u_hbi_host_model.request(io, dfr, a);
         begin
            for (int n = 0; n < 20; n++) begin
               @(posedge clock);
               #1;
               if (reqTaken === 1'b1 || reqRetry === 1'b1) break;
            end
            if (dfr) `CHK(reqTaken, take)
            else `CHK(reqTaken, take)
            `CHK(reqRetry, !take)
            if (take) begin
               qCnt++;
               defOpen = defOpen | int'(dfr);
               `CHK(queueCount, 4'(qCnt))
               `CHK(routeValid, 1'b1)
               if (io) `CHK(ioDest, ioE)
               else `CHK(memDest, memE)
               `CHK(needTranslate, ap)
               `CHK(deferIssued, dfr)
            end
         end
      join
   endtask
   task automatic retire(input int k);
      repeat (k) begin
         @(posedge clock);
         #1;
         reqDone = 1'b1;
         @(posedge clock);
         #1;
         reqDone = 1'b0;
         qCnt--;
         repeat (2) @(posedge clock);
         #1;
         `CHK(queueCount, 4'(qCnt))
      end
   endtask
   function automatic logic [31:0] pick(input logic io);
      logic [31:0] r;
      r = $urandom;
      if (io) return r[1] ? 32'h0CF8 + r[4:2] : (r[0] ? 32'hD000 + r[11:0]
         : 32'h0060);
      case (r[2:0] % 5)
         0: return {4'h0, r[31:4]};
         1: return 32'hD000_0000 + r[23:0];
         2: return 32'hE000_0000 + r[23:0];
         3: return 32'hFFFF_FFF0;
         default: return 32'h8000_0000 + r[27:0];
      endcase
   endfunction
   initial begin
      void'($urandom(32'h753C));
      #1;
      arst_n = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      arst_n = 1'b1;
      repeat (10) @(posedge clock);
      tx(64'h007F_00FF_01FF_0000);
      tx(64'hFFFF_FFFF_FFFF_FFFF);
      repeat (6) tx({$urandom, $urandom});
      $display("lane coding test done");
      rx(64'h0000_FFFF_00FE_7F00);
      repeat (6) rx({$urandom, $urandom});
      $display("lane decoding test done");
      for (int s = 1; s < 4; s++) begin
         for (int k = 0; k < 6; k++) begin
            inbound(hbi_in_src_type'(s), k % 3 == 0 ? 32'hFEE0_0000 |
               20'($urandom) : (k % 3 == 1 ? 32'h0010_0000 :
               32'h8000_0000), k < 3);
         end
      end
      $display("inbound test done");
      for (int i = 0; i < 12; i++) hostReq(i % 3 == 0, 1'b0, pick(i % 3 == 0));
      hostReq(1'b0, 1'b0, 32'h0000_1000);
      retire(12);
      $display("queue test done");
      hostReq(1'b0, 1'b1, pick(1'b0));
      hostReq(1'b0, 1'b1, pick(1'b0));
      hostReq(1'b1, 1'b0, pick(1'b1));
      @(posedge clock);
      #1;
      deferDone = 1'b1;
      @(posedge clock);
      #1;
      deferDone = 1'b0;
      defOpen = 0;
      repeat (3) @(posedge clock);
      hostReq(1'b0, 1'b1, 32'hE000_0040);
      retire(3);
      $display("deferral test done");
      results;
   end
   initial begin
      #100000;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      results;
   end
endmodule
`default_nettype wire
